// >>> common/ccd_map.svh
// Purpose: offsets, field positions, reset values and counts for the
//          chop and current-detect configuration block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   definitions only
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// ============================================================
// register offsets
`define CCD_OFS_CFG      8'h06
`define CCD_OFS_THR_HI   8'h07
`define CCD_OFS_STATUS   8'h10
`define CCD_OFS_MASK     8'h11

// ============================================================
// reset values
`define CCD_CFG_RST      16'h0600
`define CCD_THR_RST      16'h0000

// ============================================================
// configuration field positions
`define CCD_DLY_HI       12
`define CCD_DLY_LO       9
`define CCD_CHOP_EN      8
`define CCD_EVERY_CH     7
`define CCD_NUM_HI       6
`define CCD_NUM_LO       4
`define CCD_LEN_HI       3
`define CCD_LEN_LO       1
`define CCD_MODE_EN      0

// ============================================================
// status and mask bits
`define CCD_ST_SETTLED   0
`define CCD_ST_DETECT    1
`define CCD_ST_WINDOW    2
`define CCD_ST_BITS      3

// ============================================================
// measurement window lengths in conversion periods
`define CCD_WIN_0        12'd128
`define CCD_WIN_1        12'd256
`define CCD_WIN_2        12'd512
`define CCD_WIN_3        12'd768
`define CCD_WIN_4        12'd1280
`define CCD_WIN_5        12'd1792
`define CCD_WIN_6        12'd2560
`define CCD_WIN_7        12'd3584

// ============================================================
// channel count and sample width
`define CCD_NUM_CH       6
`define CCD_SMP_W        24

`endif

// >>> common/ccd_pkg.sv
// Purpose: shared types of the chop and current-detect block
// Assumes: constants come from ccd_map.svh
// Notes:   types only
package ccd_pkg;
	// ============================================================
	// settle sequencer states
	typedef enum logic [1:0] {
		CCD_SET_IDLE,
		CCD_SET_WAIT,
		CCD_SET_DONE
	} ccd_settle_t;

	typedef logic [15:0] ccd_word_t;
	typedef logic [7:0]  ccd_addr_t;
endpackage : ccd_pkg

// >>> common/ccd_if.sv
// Purpose: carries samples and threshold to the compare stage and back
// Assumes: one clock domain
// Notes:   samples are packed channel 0 in the low bits
`timescale 1ns/10ps
`include "ccd_map.svh"

interface ccd_if (
	input wire logic clk,
	input wire logic rst
);
	logic [`CCD_NUM_CH*`CCD_SMP_W-1:0] samples;
	logic                              valid;
	logic [`CCD_SMP_W-1:0]             thr;
	logic                              any_hit;
	logic                              every_hit;
	logic                              hit_valid;

	modport main_mp (input clk, rst, any_hit, every_hit, hit_valid,
		output samples, valid, thr);
	modport cmp_mp (input clk, rst, samples, valid, thr,
		output any_hit, every_hit, hit_valid);
endinterface : ccd_if

// >>> design/ccd_exceed.sv
// Purpose: per-channel magnitude compare against the detect threshold
// Assumes: one conversion per valid strobe, all channels together
// Notes:   result appears one cycle after the valid strobe
`timescale 1ns/10ps
`include "ccd_map.svh"

module ccd_exceed (
	ccd_if.cmp_mp bus
);
	import ccd_pkg::*;

	logic [`CCD_NUM_CH-1:0] over;
	logic [`CCD_SMP_W-1:0]  thr_mag;
	logic                   any_r;
	logic                   every_r;
	logic                   hv_r;

	// magnitude of a two's-complement value; full negative maps cleanly
	function automatic logic [`CCD_SMP_W-1:0] abs24(
		input logic [`CCD_SMP_W-1:0] x
	);
		abs24 = x[`CCD_SMP_W-1] ? (~x + 24'h000001) : x;
	endfunction : abs24

	assign thr_mag = abs24(bus.thr);

	// ============================================================
	// per-channel compare
	genvar ch;
	generate
		for (ch = 0; ch < `CCD_NUM_CH; ch++) begin : g_ch
			// R11: strictly greater magnitude
			assign over[ch] = abs24(bus.samples[ch*`CCD_SMP_W +: `CCD_SMP_W])
				> thr_mag;
		end
	endgenerate

	// register the reduced result beside its strobe
	always_ff @(posedge bus.clk) begin
		if (bus.rst) begin
			hv_r    <= 1'b0;
			any_r   <= 1'b0;
			every_r <= 1'b0;
		end else begin
			hv_r    <= bus.valid;
			any_r   <= |over;
			every_r <= &over;
		end
	end

	assign bus.hit_valid = hv_r;
	assign bus.any_hit   = any_r;
	assign bus.every_hit = every_r;

	// every-channel hit implies any-channel hit
	chk_all_implies_any: assert property (@(posedge bus.clk) // R5
		disable iff (bus.rst) every_r |-> any_r)
		else $error("every-channel hit without any-channel hit");
endmodule : ccd_exceed

// >>> design/ccd_chop_detect.sv
// Purpose: chop settle delay and current-detect counting with registers
// Assumes: mod_tick_in, chop_phase_in and sample_valid_in are one-cycle
//          pulses from logic on clock_in
// Notes:   status and mask layout is local to this block
// Notes on behaviour
// R1: configuration register at 06h, reset value 0600h.
// R2: software writes zeros to configuration bits 15 to 13.
// R3: wait 2^(code+1) modulator periods, code in bits 12:9, before measuring.
// R4: bit 8 turns global chop on; off after reset.
// R5: bit 7 low means any channel triggers; high needs every channel.
// R6: detection declared once exceedance count reaches 2^code, code bits 6:4.
// R7: window length from bits 3:1: 128 up to 3584 conversions.
// R8: bit 0 enables current-detect mode; off after reset.
// R9: upper threshold register at 07h, reset value 0000h.
// R10: upper threshold holds bits 23:8 of signed 24-bit threshold.
// R11: exceed means magnitude above threshold, counted inside the window.
`timescale 1ns/10ps
`include "ccd_map.svh"

module ccd_chop_detect (
	// clock and reset
	input  wire logic                               clock_in,
	input  wire logic                               sys_rst_in,
	// register port
	input  wire ccd_pkg::ccd_addr_t                 reg_addr_in,
	input  wire ccd_pkg::ccd_word_t                 reg_wdata_in,
	input  wire logic                               reg_wr_in,
	input  wire logic                               reg_rd_in,
	output      ccd_pkg::ccd_word_t                 reg_rdata_out,
	// modulator timing
	input  wire logic                               mod_tick_in,
	input  wire logic                               chop_phase_in,
	// conversion results
	input  wire logic [`CCD_NUM_CH*`CCD_SMP_W-1:0]  sample_data_in,
	input  wire logic                               sample_valid_in,
	// status outputs
	output      logic                               chop_enable_out,
	output      logic                               measure_ok_out,
	output      logic                               detect_out,
	output      logic                               irq_out
);
	import ccd_pkg::*;

	// ============================================================
	// declarations
	ccd_word_t            cfg_r;
	ccd_word_t            thr_r;
	logic [`CCD_ST_BITS-1:0] status_r;
	logic [`CCD_ST_BITS-1:0] mask_r;
	ccd_word_t            rdata_r;
	logic                 irq_r;
	logic                 detect_r;
	logic                 chop_r;
	ccd_settle_t          settle_r;
	logic [16:0]          settle_cnt_r;
	logic [16:0]          settle_tgt;
	logic                 settle_ev;
	logic                 chop_en_d_r;
	logic                 chop_start;
	logic [11:0]          win_cnt_r;
	logic [11:0]          win_len;
	logic [7:0]           exc_cnt_r;
	logic [7:0]           exc_tgt;
	logic [7:0]           exc_nxt;
	logic                 fired_r;
	logic                 hit;
	logic                 count_en;
	logic                 win_end;
	logic                 detect_ev;
	logic [`CCD_ST_BITS-1:0] events;
	logic [`CCD_ST_BITS-1:0] w1c;

	ccd_if u_if (
		.clk (clock_in),
		.rst (sys_rst_in)
	);

	ccd_exceed u_cmp (
		.bus (u_if.cmp_mp)
	);

	// address match, used by the write and read paths
	function automatic logic addr_is(
		input ccd_addr_t a,
		input ccd_addr_t ofs
	);
		addr_is = (a == ofs);
	endfunction : addr_is

	// window length lookup
	function automatic logic [11:0] len_of(input logic [2:0] code);
		case (code)
			3'h0:    len_of = `CCD_WIN_0;
			3'h1:    len_of = `CCD_WIN_1;
			3'h2:    len_of = `CCD_WIN_2;
			3'h3:    len_of = `CCD_WIN_3;
			3'h4:    len_of = `CCD_WIN_4;
			3'h5:    len_of = `CCD_WIN_5;
			3'h6:    len_of = `CCD_WIN_6;
			default: len_of = `CCD_WIN_7;
		endcase
	endfunction : len_of

	// ============================================================
	// register writes
	// R1: configuration store
	// reserved bits are kept as written, software owns them
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cfg_r <= `CCD_CFG_RST;
		end else if (reg_wr_in && addr_is(reg_addr_in, `CCD_OFS_CFG)) begin
			cfg_r <= reg_wdata_in;
		end
	end

	// R9: upper threshold store
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			thr_r <= `CCD_THR_RST;
		end else if (reg_wr_in && addr_is(reg_addr_in, `CCD_OFS_THR_HI)) begin
			thr_r <= reg_wdata_in;
		end
	end

	// interrupt mask
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mask_r <= '0;
		end else if (reg_wr_in && addr_is(reg_addr_in, `CCD_OFS_MASK)) begin
			mask_r <= reg_wdata_in[`CCD_ST_BITS-1:0];
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	assign w1c = (reg_wr_in && addr_is(reg_addr_in, `CCD_OFS_STATUS)) ?
		reg_wdata_in[`CCD_ST_BITS-1:0] : '0;
	assign events = {win_end, detect_ev, settle_ev};

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~w1c) | events;
		end
	end

	// level interrupt, registered so the pin comes from a flop
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status_r & mask_r);
		end
	end

	// ============================================================
	// register reads: data stand only in the cycle after the strobe
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || !reg_rd_in) begin
			rdata_r <= 16'h0000;
		end else if (addr_is(reg_addr_in, `CCD_OFS_CFG)) begin
			rdata_r <= cfg_r;
		end else if (addr_is(reg_addr_in, `CCD_OFS_THR_HI)) begin
			rdata_r <= thr_r;
		end else if (addr_is(reg_addr_in, `CCD_OFS_STATUS)) begin
			rdata_r <= {13'h0000, status_r};
		end else if (addr_is(reg_addr_in, `CCD_OFS_MASK)) begin
			rdata_r <= {13'h0000, mask_r};
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	// ============================================================
	// chop settle sequencer
	// R4: chop follows its enable bit
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			chop_r      <= 1'b0;
			chop_en_d_r <= 1'b0;
		end else begin
			chop_r      <= cfg_r[`CCD_CHOP_EN];
			chop_en_d_r <= cfg_r[`CCD_CHOP_EN];
		end
	end

	// restart on enable and on every chop phase change
	assign chop_start = cfg_r[`CCD_CHOP_EN] &&
		(!chop_en_d_r || chop_phase_in);
	// R3: 2^(code+1) modulator periods
	assign settle_tgt = 17'h00001 <<
		({1'b0, cfg_r[`CCD_DLY_HI:`CCD_DLY_LO]} + 5'h01);
	assign settle_ev = (settle_r == CCD_SET_WAIT) && !chop_start &&
		mod_tick_in && ((settle_cnt_r + 17'h00001) == settle_tgt);

	// R3: count ticks until the delay has passed
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			settle_r     <= CCD_SET_IDLE;
			settle_cnt_r <= 17'h00000;
		end else if (!cfg_r[`CCD_CHOP_EN]) begin
			settle_r     <= CCD_SET_IDLE;
			settle_cnt_r <= 17'h00000;
		end else if (chop_start) begin
			settle_r     <= CCD_SET_WAIT;
			settle_cnt_r <= 17'h00000;
		end else begin
			case (settle_r)
				CCD_SET_WAIT: begin
					if (settle_ev) begin
						settle_r <= CCD_SET_DONE;
					end else if (mod_tick_in) begin
						settle_cnt_r <= settle_cnt_r + 17'h00001;
					end
				end
				CCD_SET_DONE: settle_r <= CCD_SET_DONE;
				default:      settle_r <= CCD_SET_IDLE;
			endcase
		end
	end

	// measuring is free without chop, gated by settling with it
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			measure_ok_out <= 1'b1;
		end else begin
			measure_ok_out <= !cfg_r[`CCD_CHOP_EN] ||
				(settle_r == CCD_SET_DONE);
		end
	end

	// ============================================================
	// current-detect counting
	// R10: threshold is the upper sixteen bits of a 24-bit value
	assign u_if.thr     = {thr_r, 8'h00};
	assign u_if.samples = sample_data_in;
	assign u_if.valid   = sample_valid_in;

	// R5: any or every channel
	assign hit = cfg_r[`CCD_EVERY_CH] ? u_if.every_hit : u_if.any_hit;
	assign count_en = cfg_r[`CCD_MODE_EN] && u_if.hit_valid;
	// R7: window closes after its last conversion period
	assign win_len  = len_of(cfg_r[`CCD_LEN_HI:`CCD_LEN_LO]);
	assign win_end  = count_en && ((win_cnt_r + 12'h001) == win_len);
	// R6: target is 2^code exceedances
	assign exc_tgt  = 8'h01 << cfg_r[`CCD_NUM_HI:`CCD_NUM_LO];
	assign exc_nxt  = exc_cnt_r + 8'h01;
	// R11: only settled exceedances inside an open window count
	assign detect_ev = count_en && hit && measure_ok_out && !fired_r &&
		(exc_nxt == exc_tgt);

	// R8: counters run only in detect mode
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || !cfg_r[`CCD_MODE_EN]) begin
			win_cnt_r <= 12'h000;
			exc_cnt_r <= 8'h00;
			fired_r   <= 1'b0;
		end else if (win_end) begin
			win_cnt_r <= 12'h000;
			exc_cnt_r <= 8'h00;
			fired_r   <= 1'b0;
		end else if (count_en) begin
			win_cnt_r <= win_cnt_r + 12'h001;
			// one detection per window; the count stops after it
			if (hit && measure_ok_out && !fired_r) begin
				exc_cnt_r <= exc_nxt;
				fired_r   <= (exc_nxt == exc_tgt);
			end
		end
	end

	// detection pulse
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			detect_r <= 1'b0;
		end else begin
			detect_r <= detect_ev;
		end
	end

	assign reg_rdata_out   = rdata_r;
	assign chop_enable_out = chop_r;
	assign detect_out      = detect_r;
	assign irq_out         = irq_r;

	// ============================================================
	// checks
	sequence s_cfg_write;
		reg_wr_in && addr_is(reg_addr_in, `CCD_OFS_CFG);
	endsequence

	// settled flag first, then measuring is allowed one cycle later
	sequence s_settle_done;
		status_r[`CCD_ST_SETTLED] ##1 measure_ok_out;
	endsequence

	chk_cfg_reset_value: assert property (@(posedge clock_in) // R1
		sys_rst_in |=> cfg_r == `CCD_CFG_RST)
		else $error("configuration reset value wrong");

	chk_thr_reset_value: assert property (@(posedge clock_in) // R9
		sys_rst_in |=> thr_r == `CCD_THR_RST)
		else $error("threshold reset value wrong");

	chk_settle_delay_len: assert property (@(posedge clock_in) // R3
		disable iff (sys_rst_in)
		settle_ev |-> (mod_tick_in && settle_cnt_r == settle_tgt - 17'h00001)
		##1 s_settle_done)
		else $error("settle delay ended at the wrong count");

	chk_chop_enable_follow: assert property (@(posedge clock_in) // R4
		disable iff (sys_rst_in)
		s_cfg_write |=> ##1 chop_enable_out == $past(reg_wdata_in[8], 2))
		else $error("chop enable did not follow the written bit");

	chk_every_channel_gate: assert property (@(posedge clock_in) // R5
		disable iff (sys_rst_in)
		count_en && cfg_r[`CCD_EVERY_CH] && !u_if.every_hit && !win_end
		|=> exc_cnt_r == $past(exc_cnt_r))
		else $error("count moved without every channel exceeding");

	chk_detect_at_target: assert property (@(posedge clock_in) // R6
		disable iff (sys_rst_in)
		detect_ev |=> detect_out && fired_r == !$past(win_end))
		else $error("detection not flagged at the exceed target");

	chk_window_length: assert property (@(posedge clock_in) // R7
		disable iff (sys_rst_in)
		win_end |-> win_cnt_r == win_len - 12'h001 ##1 win_cnt_r == 12'h000)
		else $error("measurement window length wrong");

	chk_mode_disabled: assert property (@(posedge clock_in) // R8
		disable iff (sys_rst_in)
		!cfg_r[`CCD_MODE_EN] |-> !detect_ev
		##1 (win_cnt_r == 12'h000 && exc_cnt_r == 8'h00 && !fired_r))
		else $error("detect counters active with mode off");

	chk_upper_threshold: assert property (@(posedge clock_in) // R10
		disable iff (sys_rst_in)
		u_if.thr[23:8] == thr_r && u_if.thr[7:0] == 8'h00)
		else $error("threshold upper bits misplaced");

	chk_settle_gates_count: assert property (@(posedge clock_in) // R11
		disable iff (sys_rst_in)
		!measure_ok_out && !win_end |=> exc_cnt_r == $past(exc_cnt_r))
		else $error("exceedance counted before settling");

	// a new event keeps its status bit through a same-cycle clear
	chk_status_set_wins: assert property (@(posedge clock_in) // R6
		disable iff (sys_rst_in)
		|events |=> (status_r & $past(events)) == $past(events))
		else $error("status event lost to a clear");

	chk_irq_from_status: assert property (@(posedge clock_in) // R6
		disable iff (sys_rst_in)
		|(status_r & mask_r) |=> irq_out)
		else $error("interrupt not raised for a masked-in status bit");

	chk_read_idle_zero: assert property (@(posedge clock_in) // R1
		disable iff (sys_rst_in)
		!reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data present without a read strobe");
endmodule : ccd_chop_detect

// >>> sim/tb_ccd_chop_detect.sv
// Purpose: self-checking bench for the chop and current-detect block
// Assumes: bench drives every port itself; no far-side model
// Notes:   settle codes above 7 are not run; they only lengthen the shift
`timescale 1ns/10ps
`include "ccd_map.svh"

// ============================================================
// compare helper
`define CHK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) begin \
			errors++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module tb_ccd_chop_detect;
	import ccd_pkg::*;

	// ============================================================
	// stimulus and observed signals
	logic                 clock_in;
	logic                 sys_rst_in;
	ccd_addr_t            reg_addr_in;
	ccd_word_t            reg_wdata_in;
	logic                 reg_wr_in;
	logic                 reg_rd_in;
	ccd_word_t            reg_rdata_out;
	logic                 mod_tick_in;
	logic                 chop_phase_in;
	logic [143:0]         sample_data_in;
	logic                 sample_valid_in;
	logic                 chop_enable_out;
	logic                 measure_ok_out;
	logic                 detect_out;
	logic                 irq_out;
	int                   errors;
	int                   comparisons;
	int                   cycles;
	ccd_word_t            v;
	logic                 hit;
	int                   n;
	localparam int        TIMEOUT_CYC = 40000;
	localparam logic [23:0] OVER = 24'h001001;
	int                   win_tab [8] = '{`CCD_WIN_0, `CCD_WIN_1, `CCD_WIN_2,
		`CCD_WIN_3, `CCD_WIN_4, `CCD_WIN_5, `CCD_WIN_6, `CCD_WIN_7};

	ccd_chop_detect DUT (
		.clock_in        (clock_in),
		.sys_rst_in      (sys_rst_in),
		.reg_addr_in     (reg_addr_in),
		.reg_wdata_in    (reg_wdata_in),
		.reg_wr_in       (reg_wr_in),
		.reg_rd_in       (reg_rd_in),
		.reg_rdata_out   (reg_rdata_out),
		.mod_tick_in     (mod_tick_in),
		.chop_phase_in   (chop_phase_in),
		.sample_data_in  (sample_data_in),
		.sample_valid_in (sample_valid_in),
		.chop_enable_out (chop_enable_out),
		.measure_ok_out  (measure_ok_out),
		.detect_out      (detect_out),
		.irq_out         (irq_out)
	);

	// 50 ns period
	always #25 clock_in = ~clock_in;

	// hang guard: a stuck handshake ends the run as a mismatch
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			errors++;
			summarize();
		end
	end

	// ============================================================
	// bus and stimulus tasks
	task automatic idle(input int k);
		repeat (k) @(posedge clock_in);
	endtask : idle

	task automatic wr(input ccd_addr_t a, input ccd_word_t d);
		@(posedge clock_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clock_in);
		reg_wr_in    <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input ccd_addr_t a, output ccd_word_t d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clock_in);
		reg_rd_in   <= 1'b0;
		@(negedge clock_in);
		d = reg_rdata_out;
	endtask : rd

	// mode off first so counters and chop enable restart cleanly
	task automatic setcfg(input ccd_word_t d);
		wr(`CCD_OFS_CFG, 16'h0000);
		wr(`CCD_OFS_CFG, d);
		idle(4);
		@(negedge clock_in);
	endtask : setcfg

	// ticks are spaced so each rise of measure_ok is seen in time
	task automatic settle(output int k);
		k = 0;
		do begin
			@(posedge clock_in);
			mod_tick_in <= 1'b1;
			@(posedge clock_in);
			mod_tick_in <= 1'b0;
			k++;
			idle(3);
			@(negedge clock_in);
		end while (measure_ok_out !== 1'b1 && k < 600);
	endtask : settle

	// channel 0 gets v0, channels 1 to 5 get vr; detect pulse watched
	task automatic smp(input logic [23:0] v0, input logic [23:0] vr,
		output logic h);
		h = 1'b0;
		@(posedge clock_in);
		sample_data_in  <= {{5{vr}}, v0};
		sample_valid_in <= 1'b1;
		@(posedge clock_in);
		sample_valid_in <= 1'b0;
		repeat (4) begin
			@(negedge clock_in);
			if (detect_out === 1'b1) h = 1'b1;
		end
	endtask : smp

	// zero samples, one conversion every other cycle, to fill windows fast
	task automatic burst(input int cnt);
		repeat (cnt) begin
			@(posedge clock_in);
			sample_data_in  <= '0;
			sample_valid_in <= 1'b1;
			@(posedge clock_in);
			sample_valid_in <= 1'b0;
		end
		idle(3);
		@(negedge clock_in);
	endtask : burst

	task automatic tdone(input string nm);
		$display("test %s done, errors so far %0d", nm, errors);
	endtask : tdone

	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	// ============================================================
	// main sequence
	initial begin
		clock_in = 1'b0;
		sys_rst_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 16'h0000;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		mod_tick_in = 1'b0;
		chop_phase_in = 1'b0;
		sample_data_in = '0;
		sample_valid_in = 1'b0;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;

		// reset values, readback, unmapped place
		rd(`CCD_OFS_CFG, v);
		`CHK("cfg_reset", 16'h0600, v)
		rd(`CCD_OFS_THR_HI, v);
		`CHK("thr_reset", 16'h0000, v)
		`CHK("chop_reset", 1'b0, chop_enable_out)
		wr(`CCD_OFS_THR_HI, 16'hA5C3);
		wr(8'h3F, 16'hFFFF);
		rd(`CCD_OFS_THR_HI, v);
		`CHK("thr_rw", 16'hA5C3, v)
		rd(8'h3F, v);
		`CHK("unmapped", 16'h0000, v)
		rd(`CCD_OFS_CFG, v);
		`CHK("cfg_kept", 16'h0600, v)
		tdone("registers");

		// settle delay counts 2^(code+1) modulator ticks
		for (int c = 0; c < 8; c++) begin
			setcfg({3'b000, c[3:0], 1'b1, 8'h00});
			`CHK("chop_on", 1'b1, chop_enable_out)
			`CHK("measure_held", 1'b0, measure_ok_out)
			settle(n);
			`CHK("settle_ticks", 1 << (c + 1), n)
		end
		rd(`CCD_OFS_STATUS, v);
		`CHK("status_settled", 1'b1, v[0])
		// a chop phase change restarts the wait
		@(posedge clock_in);
		chop_phase_in <= 1'b1;
		@(posedge clock_in);
		chop_phase_in <= 1'b0;
		idle(4);
		@(negedge clock_in);
		`CHK("phase_restart", 1'b0, measure_ok_out)
		settle(n);
		`CHK("restart_ticks", 256, n)
		setcfg(16'h0000);
		`CHK("chop_off", 1'b0, chop_enable_out)
		`CHK("measure_free", 1'b1, measure_ok_out)
		tdone("settle");

		// threshold 0x001000, strict magnitude compare, interrupt path
		wr(`CCD_OFS_THR_HI, 16'h0010);
		wr(`CCD_OFS_MASK, 16'h0002);
		rd(`CCD_OFS_MASK, v);
		`CHK("mask_rw", 16'h0002, v)
		setcfg(16'h0001);
		smp(24'h001000, 24'h0, hit);
		`CHK("equal_no_hit", 1'b0, hit)
		smp(OVER, 24'h0, hit);
		`CHK("over_hit", 1'b1, hit)
		smp(OVER, 24'h0, hit);
		`CHK("once_per_window", 1'b0, hit)
		rd(`CCD_OFS_STATUS, v);
		`CHK("status_detect", 1'b1, v[1])
		`CHK("irq_set", 1'b1, irq_out)
		wr(`CCD_OFS_STATUS, 16'h0007);
		idle(2);
		@(negedge clock_in);
		`CHK("irq_clear", 1'b0, irq_out)
		setcfg(16'h0001);
		smp(24'hFFEFFF, 24'h0, hit);
		`CHK("negative_hit", 1'b1, hit)
		tdone("threshold");

		// channel condition: any versus every channel
		setcfg(16'h0001);
		smp(24'h0, OVER, hit);
		`CHK("any_channel", 1'b1, hit)
		setcfg(16'h0081);
		smp(OVER, 24'h0, hit);
		`CHK("every_partial", 1'b0, hit)
		smp(OVER, OVER, hit);
		`CHK("every_full", 1'b1, hit)
		tdone("channels");

		// exceed counts 1 up to 128: only the last one detects
		for (int k = 0; k < 8; k++) begin
			setcfg({9'h000, k[2:0], 4'h1});
			for (int i = 0; i < (1 << k); i++) begin
				smp(OVER, 24'h0, hit);
				`CHK("count_hit", (i == (1 << k) - 1), hit)
			end
		end
		setcfg(16'h0000);
		smp(OVER, OVER, hit);
		`CHK("mode_off", 1'b0, hit)
		// a mid-run reset brings the defaults back
		wr(`CCD_OFS_CFG, 16'h0181);
		@(posedge clock_in);
		sys_rst_in <= 1'b1;
		idle(2);
		sys_rst_in <= 1'b0;
		rd(`CCD_OFS_CFG, v);
		`CHK("cfg_rerst", 16'h0600, v)
		rd(`CCD_OFS_THR_HI, v);
		`CHK("thr_rerst", 16'h0000, v)
		`CHK("chop_rerst", 1'b0, chop_enable_out)
		`CHK("measure_rerst", 1'b1, measure_ok_out)
		tdone("counts");

		// no counting while the chop settle runs
		setcfg(16'h0101);
		smp(OVER, 24'h0, hit);
		`CHK("gated_no_hit", 1'b0, hit)
		settle(n);
		smp(OVER, 24'h0, hit);
		`CHK("settled_hit", 1'b1, hit)
		tdone("gating");

		// window end after exactly the tabled number of conversions
		for (int w = 0; w < 8; w++) begin
			setcfg({12'h000, w[2:0], 1'b1});
			wr(`CCD_OFS_STATUS, 16'h0007);
			burst(win_tab[w] - 1);
			rd(`CCD_OFS_STATUS, v);
			`CHK("window_open", 1'b0, v[2])
			burst(1);
			rd(`CCD_OFS_STATUS, v);
			`CHK("window_end", 1'b1, v[2])
		end
		tdone("window");
		summarize();
	end
endmodule : tb_ccd_chop_detect
